// ==== qsp_pkg.sv ====
package qsp_pkg;

	localparam int QSP_NUM_CH = 4;
	localparam logic [1:0] QSP_SLOT_RST = 2'h0;
	localparam logic [1:0] QSP_RX_SLOT_LAG = 2'h3;
	localparam logic [2:0] QSP_CHIP_ADDR_RST = 3'h0;
	localparam int QSP_EB_DEPTH = 10;
	localparam int QSP_BIT_TIME_NS = 100;
	localparam int QSP_START_LAG_NS = 400;
	localparam int QSP_EB_START_FILL = QSP_START_LAG_NS / QSP_BIT_TIME_NS;
	localparam int QSP_STRAP_TOP = 2;
	localparam int QSP_STRAP_MID = 1;
	localparam int QSP_STRAP_LOW = 0;

	typedef struct packed {
		logic crs;
		logic valid;
		logic data;
		logic coll;
	} qsp_rx_lane_t;

	typedef struct packed {
		logic [1:0] rst_sync;
		logic released;
		logic [1:0] slot;
		logic [2:0] chip_addr;
		logic [3:0] tx_en;
		logic [3:0] tx_bit;
		logic [3:0] sqe_pend;
		logic [3:0] enc_bit;
		logic [3:0] enc_strobe;
		logic [3:0] enc_etd;
		qsp_rx_lane_t rx_out;
		logic rx_drive;
		logic chip_hit;
		logic [1:0] phy_ch;
	} qsp_state_t;

	localparam qsp_state_t QSP_STATE_RST = '0;

endpackage

// ==== qsp_elastic.sv ====
`timescale 1ns/1ps
module qsp_elastic
	import qsp_pkg::*;
#(
	parameter int DEPTH = QSP_EB_DEPTH,
	parameter int START_FILL = QSP_EB_START_FILL
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wr_valid,
	input wire logic wr_bit,
	input wire logic carrier,
	input wire logic rd_slot,
	output logic have_bit,
	output logic head_bit
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [CW-1:0] count;
		logic reading;
	} qsp_eb_state_t;

	qsp_eb_state_t q;
	qsp_eb_state_t d;
	logic push;
	logic pop;

	assign have_bit = q.reading && (q.count != '0);
	assign head_bit = q.mem[q.rptr];

	always_comb begin
		d = q;
		// a full buffer drops the new bit; the frame is already broken by then
		push = wr_valid && (q.count != CW'(DEPTH));
		pop = rd_slot && have_bit;
		if (push) begin
			d.mem[q.wptr] = wr_bit;
			d.wptr = (q.wptr == PW'(DEPTH - 1)) ? '0 : q.wptr + 1'b1;
		end
		if (pop) begin
			d.rptr = (q.rptr == PW'(DEPTH - 1)) ? '0 : q.rptr + 1'b1;
		end
		case ({push, pop})
			2'b10: d.count = q.count + 1'b1;
			2'b01: d.count = q.count - 1'b1;
			default: d.count = q.count;
		endcase
		// start draining after a few bits so the slot rate never runs dry mid frame
		if (!q.reading && ((q.count >= CW'(START_FILL)) || (!carrier && q.count != '0))) begin
			d.reading = 1'b1;
		end else if (q.reading && d.count == '0) begin
			d.reading = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule // qsp_elastic

// ==== qsp_port.sv ====
`timescale 1ns/1ps
module qsp_port
	import qsp_pkg::*;
#(
	parameter int NUM_CH = QSP_NUM_CH,
	parameter int EB_DEPTH = QSP_EB_DEPTH
) (
	input wire logic clock,
	// shared hardware reset and slot strobe
	input wire logic resetn,
	input wire logic tx_slot_enable,
	input wire logic tx_slot_bit,
	input wire logic rx_slot_bit_i,
	output logic rx_slot_bit_o,
	output logic rx_slot_bit_oe_n,
	input wire logic rx_slot_valid_i,
	output logic rx_slot_valid_o,
	output logic rx_slot_valid_oe_n,
	output logic rx_carrier_sense_o,
	output logic rx_carrier_sense_oe_n,
	input wire logic slot_collision_flag_i,
	output logic slot_collision_flag_o,
	output logic slot_collision_flag_oe_n,
	output logic interrupt_out_n_o,
	output logic interrupt_out_n_oe_n,
	input wire logic collision_neg_input,
	input wire logic collision_pos_input,
	input wire logic aui_enable,
	input wire logic aui_full_duplex,
	input wire logic aui_squelch_open,
	input wire logic interrupt_mode_enable,
	input wire logic interrupt_request,
	input wire logic heartbeat_test_disable,
	input wire logic [NUM_CH-1:0] full_duplex,
	input wire logic [NUM_CH-1:0] link_pass,
	input wire logic [NUM_CH-1:0] squelch_open,
	input wire logic [NUM_CH-1:0] net_collision,
	input wire logic [NUM_CH-1:0] dec_valid,
	input wire logic [NUM_CH-1:0] dec_bit,
	output logic [NUM_CH-1:0] enc_bit,
	output logic [NUM_CH-1:0] enc_strobe,
	output logic [NUM_CH-1:0] enc_end_delim,
	input wire logic [4:0] mgmt_phy_addr,
	output logic mgmt_chip_select,
	output logic [1:0] mgmt_channel,
	output logic [2:0] chip_address
);

	qsp_state_t q;
	qsp_state_t d;
	logic rst_n;
	logic [1:0] out_ch;
	logic [NUM_CH-1:0] eb_rd;
	logic [NUM_CH-1:0] eb_have;
	logic [NUM_CH-1:0] eb_head;
	logic [NUM_CH-1:0] fd_eff;
	logic [NUM_CH-1:0] sq_eff;
	logic [NUM_CH-1:0] col_eff;
	logic aui_coll;
	logic echo;

	// internal reset is the synchronised copy; the strobe pulse passes through it too
	assign rst_n = q.rst_sync[1];

	// receive slot trails the transmit slot by one clock, same counter
	assign out_ch = q.slot + QSP_RX_SLOT_LAG;

	// single-ended mode leaves the negative pin free for the interrupt driver
	assign aui_coll = interrupt_mode_enable ? collision_pos_input
		: (collision_pos_input && !collision_neg_input);

	always_comb begin
		fd_eff = full_duplex;
		sq_eff = squelch_open;
		col_eff = net_collision;
		if (aui_enable) begin
			fd_eff[0] = aui_full_duplex;
			sq_eff[0] = aui_squelch_open;
			col_eff[0] = aui_coll;
		end
	end

	always_comb begin
		eb_rd = '0;
		if (q.released) begin
			eb_rd[out_ch] = 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			qsp_elastic #(
				.DEPTH(EB_DEPTH),
				.START_FILL(QSP_EB_START_FILL)
			) u_eb (
				.clock(clock),
				.rst_n(rst_n),
				.wr_valid(dec_valid[gi]),
				.wr_bit(dec_bit[gi]),
				.carrier(sq_eff[gi]),
				.rd_slot(eb_rd[gi]),
				.have_bit(eb_have[gi]),
				.head_bit(eb_head[gi])
			);
		end
	endgenerate

	always_comb begin
		d = q;
		echo = 1'b0;
		d.rst_sync = {q.rst_sync[0], 1'b1};
		d.enc_strobe = '0;
		d.enc_etd = '0;
		if (!rst_n) begin
			// held in reset: pins float and the slot counter waits at channel 0
			d = QSP_STATE_RST;
			d.rst_sync = {q.rst_sync[0], 1'b1};
		end else begin
			d.released = 1'b1;
			d.rx_drive = 1'b1;
			if (!q.released) begin
				// first edge after release: pins still float, straps are read now
				d.chip_addr[QSP_STRAP_TOP] = rx_slot_bit_i;
				d.chip_addr[QSP_STRAP_MID] = rx_slot_valid_i;
				d.chip_addr[QSP_STRAP_LOW] = slot_collision_flag_i;
			end
			// transmit side: current slot owns the inputs this edge
			d.slot = q.slot + 2'h1;
			d.tx_en[q.slot] = tx_slot_enable;
			if (tx_slot_enable) begin
				d.tx_bit[q.slot] = tx_slot_bit;
				d.enc_bit[q.slot] = tx_slot_bit;
				d.enc_strobe[q.slot] = 1'b1;
			end else if (q.tx_en[q.slot]) begin
				// controller stops sending; encoder closes the frame itself
				d.enc_etd[q.slot] = 1'b1;
				if (!heartbeat_test_disable) begin
					d.sqe_pend[q.slot] = 1'b1;
				end
			end
			// receive side: registered outputs for the trailing slot
			echo = !fd_eff[out_ch] && link_pass[out_ch] && q.tx_en[out_ch];
			d.rx_out.crs = sq_eff[out_ch] || echo;
			d.rx_out.valid = eb_have[out_ch] || echo;
			if (echo) begin
				d.rx_out.data = q.tx_bit[out_ch];
			end else if (eb_have[out_ch]) begin
				d.rx_out.data = eb_head[out_ch];
			end else begin
				d.rx_out.data = 1'b0;
			end
			// collision flag only in its own slot, never for full duplex
			d.rx_out.coll = (col_eff[out_ch] || q.sqe_pend[out_ch])
				&& !fd_eff[out_ch];
			if (q.sqe_pend[out_ch] && !(out_ch == q.slot && d.sqe_pend[q.slot]
				&& !q.tx_en[q.slot])) begin
				d.sqe_pend[out_ch] = 1'b0;
			end
			// management address split
			d.chip_hit = (mgmt_phy_addr[4:2] == q.chip_addr);
			d.phy_ch = mgmt_phy_addr[1:0];
		end
	end

	// asynchronous reset restarts the slot divider; a short strobe realigns to channel 0
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			q <= QSP_STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign rx_slot_bit_o = q.rx_out.data;
	assign rx_slot_valid_o = q.rx_out.valid;
	assign rx_carrier_sense_o = q.rx_out.crs;
	assign slot_collision_flag_o = q.rx_out.coll;
	assign rx_slot_bit_oe_n = !q.rx_drive;
	assign rx_slot_valid_oe_n = !q.rx_drive;
	assign rx_carrier_sense_oe_n = !q.rx_drive;
	assign slot_collision_flag_oe_n = !q.rx_drive;

	// open drain: only ever pulls low, and only when the pin is an interrupt
	assign interrupt_out_n_o = 1'b0;
	assign interrupt_out_n_oe_n = !(aui_enable && interrupt_mode_enable
		&& interrupt_request && rst_n);

	assign enc_bit = q.enc_bit;
	assign enc_strobe = q.enc_strobe;
	assign enc_end_delim = q.enc_etd;
	assign mgmt_chip_select = q.chip_hit;
	assign mgmt_channel = q.phy_ch;
	assign chip_address = q.chip_addr;

endmodule // qsp_port

// ==== qsp_port_properties.sv ====
`timescale 1ns/1ps
module qsp_port_checker (
	input wire logic clock,
	input wire logic resetn,
	input wire logic tx_slot_enable,
	input wire logic tx_slot_bit,
	input wire logic rx_slot_bit_oe_n,
	input wire logic rx_slot_valid_oe_n,
	input wire logic rx_carrier_sense_oe_n,
	input wire logic slot_collision_flag_o,
	input wire logic slot_collision_flag_oe_n,
	input wire logic interrupt_out_n_oe_n,
	input wire logic aui_enable,
	input wire logic aui_full_duplex,
	input wire logic interrupt_mode_enable,
	input wire logic interrupt_request,
	input wire logic [3:0] full_duplex,
	input wire logic [3:0] enc_bit,
	input wire logic [3:0] enc_strobe,
	input wire logic [3:0] enc_end_delim,
	input wire logic [4:0] mgmt_phy_addr,
	input wire logic mgmt_chip_select,
	input wire logic [1:0] mgmt_channel,
	input wire logic [2:0] chip_address
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	wire logic irq_on = aui_enable && interrupt_mode_enable && interrupt_request;
	wire logic all_fd = (&full_duplex) && (!aui_enable || aui_full_duplex);
	// pins start driving only once the internal reset copy is released
	wire logic up = !rx_carrier_sense_oe_n;
	property p_float; disable iff (1'b0) !resetn |-> rx_slot_bit_oe_n && rx_slot_valid_oe_n
		&& rx_carrier_sense_oe_n && slot_collision_flag_oe_n; endproperty
	a_float: assert property (p_float) else $error("pins driven in reset");
	property p_one; $onehot0(enc_strobe); endproperty
	a_one: assert property (p_one) else $error("two channels at once");
	property p_stb; |enc_strobe |-> $past(tx_slot_enable); endproperty
	a_stb: assert property (p_stb) else $error("bit taken without enable");
	property p_bit; |enc_strobe |-> ((enc_bit ^ {4{$past(tx_slot_bit)}}) & enc_strobe) == 4'h0;
	endproperty
	a_bit: assert property (p_bit) else $error("encoder bit wrong");
	property p_etd; |enc_end_delim |-> !$past(tx_slot_enable); endproperty
	a_etd: assert property (p_etd) else $error("delimiter while enabled");
	property p_fd; all_fd && $past(all_fd) && $past(all_fd, 2) |-> !slot_collision_flag_o;
	endproperty
	a_fd: assert property (p_fd) else $error("collision in full duplex");
	property p_int; up && $past(up) && irq_on == $past(irq_on) |-> interrupt_out_n_oe_n == !irq_on;
	endproperty
	a_int: assert property (p_int) else $error("interrupt pin wrong");
	property p_sel; up && $stable(chip_address) |-> mgmt_channel == $past(mgmt_phy_addr[1:0])
		&& mgmt_chip_select == ($past(mgmt_phy_addr[4:2]) == chip_address); endproperty
	a_sel: assert property (p_sel) else $error("chip select wrong");
endmodule // qsp_port_checker
bind qsp_port qsp_port_checker chk (.*);

// ==== qsp_ctrl_model.sv ====
`timescale 1ns/1ps
module qsp_ctrl_model (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [3:0] en_pat,
	input wire logic [3:0] bit_pat,
	output logic tx_slot_enable = 1'h0,
	output logic tx_slot_bit = 1'h0
);
	int c = 0;
	int k;
	// channel 0 is taken at the third edge after reset/strobe release
	always @(posedge clock) begin
		c = resetn ? c + 1 : 0;
		k = (c + 2) % 4;
		tx_slot_enable <= en_pat[k];
		// idle slots toggle the bit so a stale value is never mistaken for data
		tx_slot_bit <= en_pat[k] ? bit_pat[k] : ~tx_slot_bit;
	end
endmodule // qsp_ctrl_model

// ==== tb_quad_channel_tdm_serial_port.sv ====
`timescale 1ns/1ps
module tb_quad_channel_tdm_serial_port;
	logic clock = 1'h0, resetn = 1'h1, rst_next = 1'h0, pu_bit = 1'h1, pu_col = 1'h1;
	logic tx_slot_enable, tx_slot_bit, rx_slot_bit_i, rx_slot_bit_o, rx_slot_bit_oe_n;
	logic rx_slot_valid_i, rx_slot_valid_o, rx_slot_valid_oe_n, rx_carrier_sense_o;
	logic rx_carrier_sense_oe_n, slot_collision_flag_i, slot_collision_flag_o;
	logic slot_collision_flag_oe_n, interrupt_out_n_o, interrupt_out_n_oe_n, mgmt_chip_select;
	logic collision_neg_input = 1'h0, collision_pos_input = 1'h0, aui_enable = 1'h0;
	logic aui_full_duplex = 1'h0, aui_squelch_open = 1'h0, interrupt_mode_enable = 1'h0;
	logic interrupt_request = 1'h0, heartbeat_test_disable = 1'h1;
	logic [3:0] full_duplex = 4'h0, link_pass = 4'h0, squelch_open = 4'h0, net_collision = 4'h0;
	logic [3:0] dec_valid = 4'h0, dec_bit = 4'h0, en_pat = 4'h0, bit_pat = 4'h0;
	logic [3:0] enc_bit, enc_strobe, enc_end_delim;
	logic [4:0] mgmt_phy_addr = 5'h00, pa_used;
	logic [1:0] mgmt_channel;
	logic [2:0] chip_address, exp_chip = 3'h5;
	int cyc = 0, nd = 0, nh = 0, num_errors = 0, n_compared = 0;
	always #20 clock = ~clock;
	assign rx_slot_bit_i = rx_slot_bit_oe_n ? pu_bit : rx_slot_bit_o;
	assign rx_slot_valid_i = rx_slot_valid_oe_n ? 1'h0 : rx_slot_valid_o;
	assign slot_collision_flag_i = slot_collision_flag_oe_n ? pu_col : slot_collision_flag_o;
	qsp_port uut (.*);
	qsp_ctrl_model ctrl (.*);
	task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("mismatches %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic tick;
		@(posedge clock);
		cyc = resetn ? cyc + 1 : 0;
		pa_used = mgmt_phy_addr;
		mgmt_phy_addr <= mgmt_phy_addr + 5'h03;
		resetn <= rst_next;
	endtask
	task automatic row(input logic [3:0] e, b, lp, fd, nc, sq, input logic [4:0] a);
		tick();
		en_pat <= e;
		bit_pat <= b;
		link_pass <= lp;
		full_duplex <= fd;
		net_collision <= nc;
		squelch_open <= sq;
		{aui_enable, aui_full_duplex, collision_pos_input, interrupt_mode_enable,
			interrupt_request} <= a;
	endtask
	task automatic run(input int n);
		int ch;
		int k;
		int i;
		logic [3:0] ec;
		logic [3:0] cl;
		for (i = 0; i < n; i++) begin
			tick();
			#5;
			nd += enc_end_delim[1];
			nh += slot_collision_flag_o;
			ch = cyc % 4;
			k = (cyc + 1) % 4;
			ec = link_pass & ~full_duplex & en_pat;
			cl = net_collision & ~full_duplex;
			if (aui_enable) cl[0] = collision_pos_input & ~aui_full_duplex;
			// a new pattern needs a full slot round plus pipeline before the echo settles
			if (cyc > 8 && i >= 6) begin
				check("crs", rx_carrier_sense_o, squelch_open[ch] | ec[ch]);
				check("valid", rx_slot_valid_o, ec[ch]);
				if (!ec[ch]) check("data", rx_slot_bit_o, 4'h0);
				else check("echo", rx_slot_bit_o, bit_pat[ch]);
				check("coll", slot_collision_flag_o, cl[ch]);
				check("stb", enc_strobe, en_pat[k] ? 4'h1 << k : 4'h0);
				check("bit", enc_bit[k] & en_pat[k], bit_pat[k] & en_pat[k]);
				check("int", interrupt_out_n_oe_n, !(aui_enable & interrupt_mode_enable
					& interrupt_request));
				check("sel", {mgmt_chip_select, mgmt_channel},
					{pa_used[4:2] == exp_chip, pa_used[1:0]});
				check("chip", chip_address, exp_chip);
			end
		end
	endtask
	initial begin
		#1 resetn = 1'h0;
		repeat (16) tick();
		#5 check("float", {rx_slot_bit_oe_n, rx_slot_valid_oe_n, rx_carrier_sense_oe_n,
			slot_collision_flag_oe_n}, 4'hF);
		rst_next = 1'h1;
		row(4'h5, 4'h4, 4'h1, 4'h0, 4'h2, 4'h8, 5'h00);
		run(16);
		row(4'hF, 4'hA, 4'hF, 4'h3, 4'hF, 4'h0, 5'h00);
		run(16);
		row(4'h2, 4'h2, 4'h0, 4'h0, 4'h0, 4'h4, 5'h14);
		run(16);
		row(4'h2, 4'h0, 4'h0, 4'hF, 4'hF, 4'h4, 5'h1C);
		run(16);
		row(4'h2, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 5'h17);
		run(16);
		nd = 0;
		nh = 0;
		heartbeat_test_disable <= 1'h0;
		row(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 5'h00);
		run(16);
		check("etd", 4'(nd), 4'h1);
		check("sqe", 4'(nh), 4'h1);
		// one-clock strobe with no pull-ups: slots realign and address re-straps to zero
		pu_bit = 1'h0;
		pu_col = 1'h0;
		exp_chip = 3'h0;
		rst_next = 1'h0;
		tick();
		rst_next = 1'h1;
		#5 check("float", {rx_slot_bit_oe_n, rx_carrier_sense_oe_n}, 4'h3);
		row(4'h5, 4'h4, 4'h1, 4'h0, 4'h2, 4'h8, 5'h00);
		run(16);
		stop_test();
	end
endmodule // tb_quad_channel_tdm_serial_port
